// *** hdl/ews_pkg.sv ***
package ews_pkg;
   localparam int unsigned CLK_MHZ          = 200;
   // times in nanoseconds, converted to cycles below
   localparam int unsigned WAKE_1G_NS       = 17000;
   localparam int unsigned WAKE_OTHER_NS    = 30000;
   localparam int unsigned HOLD_NS          = 48000;
   // least times round up
   localparam int unsigned WAKE_1G_CYC      = (WAKE_1G_NS * CLK_MHZ + 999) / 1000;
   localparam int unsigned WAKE_OTHER_CYC   = (WAKE_OTHER_NS * CLK_MHZ + 999) / 1000;
   // longest time rounds down
   localparam int unsigned HOLD_CYC         = (HOLD_NS * CLK_MHZ) / 1000;
   localparam int unsigned BYTE_THRESHOLD   = 3000;
   localparam int unsigned NUM_QUEUES       = 8;
   localparam int unsigned BYTE_CNT_W       = 16;
   localparam int unsigned TIMER_W          = 16;
   // link speed codes
   localparam logic [1:0]  SPEED_10M        = 2'h0;
   localparam logic [1:0]  SPEED_100M       = 2'h1;
   localparam logic [1:0]  SPEED_1G         = 2'h2;
   typedef enum logic [1:0] {
      EWS_ACTIVE,
      EWS_SLEEP,
      EWS_HOLD,
      EWS_WAKE
   } ews_state_t;
endpackage : ews_pkg

// *** hdl/ews_countdown.sv ***
`timescale 1ns/1ps
// loadable down counter; done is a level while the count sits at zero
module ews_countdown #(
   parameter int unsigned W = 16
) (
   input  wire logic          clock,
   input  wire logic          sys_rst,
   input  wire logic          load,
   input  wire logic [W-1:0]  load_val,
   input  wire logic          run,
   output logic               done
);
   if (W < 1)
   begin : g_bad_w
      $error("counter width must be at least one bit");
   end

   logic [W-1:0] cnt_r;
   logic [W-1:0] cnt_nxt;

   always_comb
   begin
      cnt_nxt = cnt_r;
      if (load)
      begin
         cnt_nxt = load_val;
      end
      else if (run && cnt_r != '0)
      begin
         cnt_nxt = cnt_r - W'(1);
      end
   end

   always_ff @(posedge clock or posedge sys_rst)
   begin
      if (sys_rst)
         cnt_r <= '0;
      else
         cnt_r <= cnt_nxt;
   end

   assign done = (cnt_r == '0);
endmodule : ews_countdown

// *** hdl/ews_tx_wake_scheduler.sv ***
`timescale 1ns/1ps
// Summary of operation
// - wakeup interval is 17 us at 1 Gbit/s, 30 us otherwise
// - transmit circuits stay powered down while idle, powered up when needed
// - non-urgent data is held until 3000 bytes are pending
// - held data starts power-up anyway 48 us after it first arrived
// - urgent queue data starts power-up at once
// - no frame is sent before the wakeup interval has elapsed
// - power saving only on autoneg ports at 1G or 100M full duplex
// - power saving only on ports whose enable is set
module ews_tx_wake_scheduler #(
   parameter int unsigned NQ      = ews_pkg::NUM_QUEUES,
   parameter int unsigned BCW     = ews_pkg::BYTE_CNT_W,
   parameter int unsigned HOLD    = ews_pkg::HOLD_CYC,
   parameter int unsigned WAKE_1G = ews_pkg::WAKE_1G_CYC,
   parameter int unsigned WAKE_OT = ews_pkg::WAKE_OTHER_CYC
) (
   input  wire logic            clock,
   input  wire logic            sys_rst,
   input  wire logic            eee_enable,
   input  wire logic [NQ-1:0]   urgent_queues,
   input  wire logic            link_up,
   input  wire logic            autoneg_done,
   input  wire logic            full_duplex,
   input  wire logic [1:0]      link_speed,
   input  wire logic [NQ-1:0]   queue_nonempty,
   input  wire logic [BCW-1:0]  pending_bytes,
   output logic                 tx_power_down,
   output logic                 tx_release,
   output logic                 lpi_active
);
   localparam int unsigned TW = ews_pkg::TIMER_W;

   // refused at elaboration: the logic below cannot serve these values
   if (NQ < 1 || NQ > 64)
   begin : g_bad_nq
      $error("queue count out of range");
   end
   if (HOLD >= (1 << TW) || WAKE_1G >= (1 << TW) || WAKE_OT >= (1 << TW))
   begin : g_bad_tw
      $error("timer width too small");
   end
   if (HOLD < 1 || WAKE_1G < 1 || WAKE_OT < 1)
   begin : g_bad_min
      $error("timer values must be at least one cycle");
   end
   // a threshold the counter cannot hold would never be reached
   if (ews_pkg::BYTE_THRESHOLD >= (1 << BCW))
   begin : g_bad_bcw
      $error("byte counter too narrow for threshold");
   end

   // link status comes from the phy side, other clock timing: synchronise
   logic [4:0] lnk_s1_r;
   logic [4:0] lnk_s1_nxt;
   logic [4:0] lnk_s2_r;
   logic [4:0] lnk_s2_nxt;

   // first stage is read only by the second; metastability settles there
   always_comb
   begin
      lnk_s1_nxt = {link_up, autoneg_done, full_duplex, link_speed};
      lnk_s2_nxt = lnk_s1_r;
   end

   always_ff @(posedge clock or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         lnk_s1_r <= 5'h00;
         lnk_s2_r <= 5'h00;
      end
      else
      begin
         lnk_s1_r <= lnk_s1_nxt;
         lnk_s2_r <= lnk_s2_nxt;
      end
   end

   logic       s_up;
   logic       s_an;
   logic       s_fd;
   logic [1:0] s_speed;
   assign {s_up, s_an, s_fd, s_speed} = lnk_s2_r;

   function automatic logic eee_capable(input logic an, input logic fd, input logic [1:0] sp);
      eee_capable = an && fd && (sp == ews_pkg::SPEED_1G || sp == ews_pkg::SPEED_100M);
   endfunction : eee_capable

   logic saving_ok;
   assign saving_ok = eee_enable && s_up && eee_capable(s_an, s_fd, s_speed);

   // speed is taken when wake starts; a later change waits for the next wake
   logic [TW-1:0] wake_cycles;
   assign wake_cycles = (s_speed == ews_pkg::SPEED_1G) ? TW'(WAKE_1G) : TW'(WAKE_OT);

   logic any_data;
   logic urgent_data;
   logic thresh_hit;
   assign any_data    = |queue_nonempty;
   assign urgent_data = |(queue_nonempty & urgent_queues);
   // at least the threshold, not strictly above it
   assign thresh_hit  = pending_bytes >= BCW'(ews_pkg::BYTE_THRESHOLD);

   ews_pkg::ews_state_t st_r;
   ews_pkg::ews_state_t st_nxt;
   logic                pd_r;
   logic                pd_nxt;
   logic                rel_r;
   logic                rel_nxt;
   logic                lpi_r;
   logic                lpi_nxt;
   logic                tmr_load;
   logic [TW-1:0]       tmr_val;
   logic                tmr_done;

   // one timer serves hold and wake; done stays up at zero until reloaded
   ews_countdown #(
      .W        (TW)
   ) u_timer (
      .clock    (clock),
      .sys_rst  (sys_rst),
      .load     (tmr_load),
      .load_val (tmr_val),
      .run      (1'b1),
      .done     (tmr_done)
   );

   always_comb
   begin
      st_nxt   = st_r;
      tmr_load = 1'b0;
      tmr_val  = '0;
      case (st_r)
         ews_pkg::EWS_ACTIVE:
         begin
            // go to sleep only once every queue has drained
            if (saving_ok && !any_data)
            begin
               st_nxt = ews_pkg::EWS_SLEEP;
            end
         end
         ews_pkg::EWS_SLEEP:
         begin
            if (!saving_ok || urgent_data || (any_data && thresh_hit))
            begin
               st_nxt   = ews_pkg::EWS_WAKE;
               tmr_load = 1'b1;
               tmr_val  = wake_cycles;
            end
            // first arrival while asleep starts the hold-off
            else if (any_data)
            begin
               st_nxt   = ews_pkg::EWS_HOLD;
               tmr_load = 1'b1;
               tmr_val  = TW'(HOLD);
            end
         end
         ews_pkg::EWS_HOLD:
         begin
            // hold timer from first arrival bounds latency
            if (!saving_ok || urgent_data || thresh_hit || tmr_done)
            begin
               st_nxt   = ews_pkg::EWS_WAKE;
               tmr_load = 1'b1;
               tmr_val  = wake_cycles;
            end
         end
         ews_pkg::EWS_WAKE:
         begin
            // circuits must be fully up at both ends before release
            if (tmr_done)
            begin
               st_nxt = ews_pkg::EWS_ACTIVE;
            end
         end
         default:
         begin
            st_nxt = ews_pkg::EWS_ACTIVE;
         end
      endcase
   end

   always_ff @(posedge clock or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         st_r <= ews_pkg::EWS_ACTIVE;
      end
      else
      begin
         st_r <= st_nxt;
      end
   end

   // flags follow the next state so they change on the same edge as st_r
   always_comb
   begin
      pd_nxt  = (st_nxt == ews_pkg::EWS_SLEEP) || (st_nxt == ews_pkg::EWS_HOLD);
      rel_nxt = (st_nxt == ews_pkg::EWS_ACTIVE);
      lpi_nxt = (st_nxt != ews_pkg::EWS_ACTIVE);
   end

   // reset leaves the port transmitting: saving is only entered once link is known
   always_ff @(posedge clock or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         pd_r  <= 1'b0;
         rel_r <= 1'b1;
         lpi_r <= 1'b0;
      end
      else
      begin
         pd_r  <= pd_nxt;
         rel_r <= rel_nxt;
         lpi_r <= lpi_nxt;
      end
   end

   assign tx_power_down = pd_r;
   assign tx_release    = rel_r;
   assign lpi_active    = lpi_r;
endmodule : ews_tx_wake_scheduler

// *** test/ews_link_peer.sv ***
`timescale 1ns/1ps
// far end: counts cycles spent waking, takes no frame before release
module ews_link_peer (
   input  wire logic clock,
   input  wire logic tx_power_down,
   input  wire logic tx_release,
   output int        wake_cycles
);
   always @(posedge clock)
      if (tx_power_down) wake_cycles <= 0;
      else if (!tx_release) wake_cycles <= wake_cycles + 1;
endmodule : ews_link_peer

// *** test/ews_monitor.sv ***
`timescale 1ns/1ps
module ews_monitor #(
   parameter int unsigned HOLD = 20
) (
   input wire logic        clock,
   input wire logic        sys_rst,
   input wire logic        eee_enable,
   input wire logic [7:0]  urgent_queues,
   input wire logic        full_duplex,
   input wire logic [1:0]  link_speed,
   input wire logic [7:0]  queue_nonempty,
   input wire logic [15:0] pending_bytes,
   input wire logic        tx_power_down,
   input wire logic        tx_release,
   input wire logic        lpi_active
);
   logic [15:0] held_r;
   default clocking @(posedge clock); endclocking
   default disable iff (sys_rst);
   always_ff @(posedge clock or posedge sys_rst)
      if (sys_rst) held_r <= '0;
      else held_r <= (tx_power_down && |queue_nonempty) ? held_r + 16'h1 : '0;
   property p_rel; tx_release |-> !tx_power_down && !lpi_active; endproperty
   a_rel: assert property (p_rel) else $error("release while saving");
   property p_pd; tx_power_down |-> lpi_active; endproperty
   a_pd: assert property (p_pd) else $error("powered down without lpi");
   property p_wmin; $fell(tx_power_down) |-> !tx_release [*5]; endproperty
   a_wmin: assert property (p_wmin) else $error("wake too short");
   property p_wmax; $fell(tx_power_down) |-> ##[1:12] tx_release; endproperty
   a_wmax: assert property (p_wmax) else $error("wake too long");
   property p_urg; tx_power_down && |(queue_nonempty & urgent_queues) |=> !tx_power_down;
   endproperty
   a_urg: assert property (p_urg) else $error("urgent data left asleep");
   property p_thr; tx_power_down && |queue_nonempty && pending_bytes >= 16'hbb8
      |=> !tx_power_down; endproperty
   a_thr: assert property (p_thr) else $error("threshold ignored");
   property p_en; tx_power_down && !eee_enable |=> !tx_power_down; endproperty
   a_en: assert property (p_en) else $error("disabled port asleep");
   property p_hold; held_r <= HOLD + 3; endproperty
   a_hold: assert property (p_hold) else $error("hold time overrun");
   property p_spd; $rose(tx_power_down) |-> $past(full_duplex, 3)
      && $past(link_speed, 3) != ews_pkg::SPEED_10M && $past(queue_nonempty) == 8'h00;
   endproperty
   a_spd: assert property (p_spd) else $error("bad sleep entry");
   c_wake: cover property ($fell(tx_power_down));
   c_hold: cover property (held_r == HOLD);
   c_urg: cover property (tx_power_down && |(queue_nonempty & urgent_queues));
endmodule : ews_monitor

// *** test/ews_tx_wake_scheduler_test.sv ***
`timescale 1ns/1ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin num_errors++; \
   $display("wrong value at %0t: got %h expected %h", $time, a, b); end end
module ews_tx_wake_scheduler_test;
   localparam int unsigned HOLD = 20;
   localparam int unsigned WK1  = 5;
   localparam int unsigned WKO  = 8;
   logic        clock, sys_rst, eee_enable, link_up, autoneg_done, full_duplex;
   logic [1:0]  link_speed;
   logic [7:0]  urgent_queues, queue_nonempty;
   logic [15:0] pending_bytes;
   logic        tx_power_down, tx_release, lpi_active;
   logic [4:0]  bad [4] = '{5'h07, 5'h13, 5'h15, 5'h16};
   int          wake_cycles, num_errors, checks_done, ticks;
   ews_tx_wake_scheduler #(.HOLD(HOLD), .WAKE_1G(WK1), .WAKE_OT(WKO)) dut_u (
      .clock          (clock),
      .sys_rst        (sys_rst),
      .eee_enable     (eee_enable),
      .urgent_queues  (urgent_queues),
      .link_up        (link_up),
      .autoneg_done   (autoneg_done),
      .full_duplex    (full_duplex),
      .link_speed     (link_speed),
      .queue_nonempty (queue_nonempty),
      .pending_bytes  (pending_bytes),
      .tx_power_down  (tx_power_down),
      .tx_release     (tx_release),
      .lpi_active     (lpi_active)
   );
   ews_link_peer peer_u (
      .clock         (clock),
      .tx_power_down (tx_power_down),
      .tx_release    (tx_release),
      .wake_cycles   (wake_cycles)
   );
   initial
   begin
      clock = 0;
      forever #2.5 clock = ~clock;
   end
   always @(posedge clock)
   begin
      ticks++;
      if (ticks == 3000)
      begin
         num_errors++;
         stop_test();
      end
   end
   task cyc(input int n); repeat (n) @(negedge clock); endtask : cyc
   task wait_pd(input logic v);
      for (int i = 0; i < 40 && tx_power_down !== v; i++) @(negedge clock);
   endtask : wait_pd
   task wake_chk(input int wk);
      for (int i = 0; i < 20 && tx_release !== 1'b1; i++) @(negedge clock);
      `CHK(wake_cycles >= wk && wake_cycles <= wk + 2, 1'b1)
   endtask : wake_chk
   task idle();
      queue_nonempty = '0;
      pending_bytes = '0;
      wait_pd(1);
      `CHK({tx_power_down, tx_release, lpi_active}, 3'h5)
   endtask : idle
   task t_hold();
      int t0;
      queue_nonempty = 8'h02;
      pending_bytes = 16'h0064;
      t0 = ticks;
      cyc(HOLD - 2);
      `CHK(tx_power_down, 1'b1)
      wait_pd(0);
      `CHK(ticks - t0 <= HOLD + 3, 1'b1)
      wake_chk(WK1);
      idle();
      $display("hold test done");
   endtask : t_hold
   task t_thr();
      pending_bytes = 16'h0bb7;
      queue_nonempty = 8'h04;
      cyc(3);
      `CHK(tx_power_down, 1'b1)
      pending_bytes = 16'h0bb8;
      cyc(1);
      `CHK(tx_power_down, 1'b0)
      `CHK({tx_release, lpi_active}, 2'h1)
      wake_chk(WK1);
      idle();
      $display("threshold test done");
   endtask : t_thr
   task t_rst();
      sys_rst = 1;
      cyc(2);
      `CHK({tx_power_down, tx_release, lpi_active}, 3'h2)
      sys_rst = 0;
      idle();
      $display("reset test done");
   endtask : t_rst
   task t_urg();
      link_speed = ews_pkg::SPEED_100M;
      cyc(4);
      queue_nonempty = 8'h01;
      cyc(1);
      `CHK(tx_power_down, 1'b0)
      wake_chk(WKO);
      idle();
      $display("urgent test done");
   endtask : t_urg
   task t_off();
      for (int k = 0; k < 5; k++)
      begin
         eee_enable = 0;
         cyc(12);
         `CHK(tx_release, 1'b1)
         {link_speed, full_duplex, autoneg_done, link_up} = (k < 4) ? bad[k] : 5'h17;
         cyc(4);
         eee_enable = 1;
         cyc(10);
         `CHK(tx_power_down, k == 4)
      end
      $display("disable test done");
   endtask : t_off
   task stop_test();
      $display("checks %0d errors %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : stop_test
   initial
   begin
      sys_rst = 1;
      eee_enable = 1;
      {link_speed, full_duplex, autoneg_done, link_up} = 5'h17;
      urgent_queues = 8'h01;
      queue_nonempty = '0;
      pending_bytes = '0;
      cyc(8);
      sys_rst = 0;
      idle();
      t_hold();
      t_thr();
      t_rst();
      t_urg();
      t_off();
      stop_test();
   end
endmodule : ews_tx_wake_scheduler_test
bind ews_tx_wake_scheduler ews_monitor #(.HOLD(HOLD)) mon_u (
   .clock          (clock),
   .sys_rst        (sys_rst),
   .eee_enable     (eee_enable),
   .urgent_queues  (urgent_queues),
   .full_duplex    (full_duplex),
   .link_speed     (link_speed),
   .queue_nonempty (queue_nonempty),
   .pending_bytes  (pending_bytes),
   .tx_power_down  (tx_power_down),
   .tx_release     (tx_release),
   .lpi_active     (lpi_active)
);
